// file: core/bdc_count_control.sv
// bridge dma channel one: transfer count and control logic with register slave
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module bdc_count_control
   import bdc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // register port
   input  wire bdc_bus_s    bus,
   output logic [31:0]      rdata,
   // transfer engine side
   input  wire logic        dma_req,
   input  wire logic        unit_done,
   output logic             xfer_go,
   output logic             unit_ack,
   output logic             term_count,
   // interrupt
   output logic             irq
);

   bdc_state_s s_q;
   bdc_state_s s_d;
   logic       req_m_q;
   logic       req_s_q;
   logic [19:0] step;
   logic        start_cmd;
   logic        cancel_cmd;
   logic        launch;
   logic [1:0]  ev;
   logic        at_zero;

   // request pin synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_m_q <= 1'b0;
         req_s_q <= 1'b0;
      end else begin
         req_m_q <= dma_req;
         req_s_q <= req_m_q;
      end
   end

   // count step per destination size
   always_comb begin
      case (s_q.dst)
         BDC_DST_HALF: step = BDC_STEP_HALF;
         BDC_DST_WORD: step = BDC_STEP_WORD;
         default:      step = BDC_STEP_BYTE;
      endcase
   end

   assign start_cmd  = bus.wr && (bus.addr == BDC_OFS_CMD) && bus.wdata[BDC_CMD_START];
   assign cancel_cmd = bus.wr && (bus.addr == BDC_OFS_CMD) && bus.wdata[BDC_CMD_CANCEL];
   // a launch needs enable; requests also need request disable at 00
   assign launch = s_q.en && (start_cmd || (req_s_q && s_q.request_disable_field == 2'h0));
   assign at_zero = (s_q.current_transfer_count <= step);

   // next state
   always_comb begin
      s_d = s_q;
      s_d.unit_ack = 1'b0;
      s_d.tc = 1'b0;
      ev = 2'h0;
      case (s_q.st)
         BDC_IDLE: begin
            if (s_q.en) begin
               s_d.st = BDC_ARMED;
            end
         end
         BDC_ARMED: begin
            if (!s_q.en) begin
               s_d.st = BDC_IDLE;
            end else if (launch) begin
               s_d.current_transfer_count = s_q.initial_transfer_count;
               s_d.st = BDC_BUSY;
            end
         end
         BDC_BUSY: begin
            if (unit_done) begin
               s_d.unit_ack = 1'b1;
               ev[BDC_ST_UNIT] = 1'b1;
               if (at_zero) begin
                  ev[BDC_ST_TC] = 1'b1;
                  s_d.tc = 1'b1;
                  if (s_q.ar) begin
                     s_d.current_transfer_count = s_q.initial_transfer_count;
                     s_d.st = BDC_ARMED;
                  end else begin
                     s_d.current_transfer_count = 20'h00000;
                     s_d.en = 1'b0;
                     s_d.st = BDC_IDLE;
                  end
               end else begin
                  s_d.current_transfer_count = s_q.current_transfer_count - step;
               end
            end
         end
         default: s_d.st = BDC_IDLE;
      endcase
      // cancel wins over the state and enable updates
      if (cancel_cmd) begin
         s_d.en = 1'b0;
         s_d.st = BDC_IDLE;
      end
      // register writes
      if (bus.wr) begin
         case (bus.addr)
            BDC_OFS_INIT: begin
               s_d.src  = bus.wdata[BDC_SRC_LSB +: 2];
               s_d.mode = bus.wdata[BDC_MODE_LSB +: 2];
               s_d.ar   = bus.wdata[BDC_AR_BIT];
               s_d.initial_transfer_count = bus.wdata[BDC_CNT_W-1:0];
               if (!cancel_cmd) begin
                  s_d.en = bus.wdata[BDC_EN_BIT];
               end
            end
            BDC_OFS_MASK: s_d.mask = bus.wdata[1:0];
            BDC_OFS_CTRL: begin
               s_d.request_disable_field = bus.wdata[1:0];
               s_d.dst = bus.wdata[5:4];
            end
            default: ;
         endcase
      end
      // sticky status: set wins over write-one clear, gated by mode
      if (bus.wr && bus.addr == BDC_OFS_STAT) begin
         s_d.stat = s_q.stat & ~bus.wdata[1:0];
      end
      if (s_q.mode == BDC_MODE_UNIT) begin
         s_d.stat[BDC_ST_UNIT] = s_d.stat[BDC_ST_UNIT] | ev[BDC_ST_UNIT];
      end
      if (s_q.mode == BDC_MODE_TC) begin
         s_d.stat[BDC_ST_TC] = s_d.stat[BDC_ST_TC] | ev[BDC_ST_TC];
      end
      // read data, one cycle later
      s_d.rdata = 32'h00000000;
      if (bus.rd) begin
         case (bus.addr)
            BDC_OFS_INIT: s_d.rdata = {s_q.src, BDC_FIXED_FIELDS, s_q.mode, s_q.ar,
                                       s_q.en, s_q.initial_transfer_count};
            BDC_OFS_CUR:  s_d.rdata = {s_q.src, BDC_FIXED_FIELDS, s_q.mode, s_q.ar,
                                       s_q.en, s_q.current_transfer_count};
            BDC_OFS_STAT: s_d.rdata = {30'h00000000, s_q.stat};
            BDC_OFS_MASK: s_d.rdata = {30'h00000000, s_q.mask};
            BDC_OFS_CTRL: s_d.rdata = {26'h0000000, s_q.dst, 2'h0, s_q.request_disable_field};
            default:      s_d.rdata = 32'h00000000;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: BDC_IDLE, src: BDC_SRC_RST, mode: BDC_MODE_RST, ar: 1'b0, en: 1'b0,
                  initial_transfer_count: 20'h00000, current_transfer_count: 20'h00000, request_disable_field: BDC_QDS_RST, dst: BDC_DST_RST,
                  stat: 2'h0, mask: 2'h0, unit_ack: 1'b0, tc: 1'b0, rdata: 32'h00000000};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   assign rdata      = s_q.rdata;
   assign xfer_go    = (s_q.st == BDC_BUSY);
   assign unit_ack   = s_q.unit_ack;
   assign term_count = s_q.tc;
   assign irq        = |(s_q.stat & s_q.mask);

   // assertions
   a_no_move_disabled: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_ARMED && !s_q.en) |=> (s_q.st != BDC_BUSY))
      else $error("busy without enable");
   a_cancel_clears_en: assert property (@(posedge clk) disable iff (!rst_n)
      cancel_cmd |=> (!s_q.en && s_q.st == BDC_IDLE))
      else $error("cancel did not clear enable");
   a_tc_clears_en: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_BUSY && unit_done && at_zero && !s_q.ar && !cancel_cmd && !bus.wr)
      |=> !s_q.en)
      else $error("enable kept at terminal count");
   a_reload_keeps_en: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_BUSY && unit_done && at_zero && s_q.ar && !cancel_cmd && !bus.wr)
      |=> (s_q.en && s_q.current_transfer_count == $past(s_q.initial_transfer_count) && s_q.st == BDC_ARMED))
      else $error("auto-reload failed");
   a_wait_relaunch: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_ARMED && !launch) |=> (s_q.st != BDC_BUSY))
      else $error("moved without start or request");
   a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_BUSY && unit_done && !at_zero && !cancel_cmd)
      |=> (s_q.current_transfer_count == $past(s_q.current_transfer_count) - $past(step)))
      else $error("count step wrong");
   a_launch_loads: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_ARMED && launch && !cancel_cmd)
      |=> (s_q.st == BDC_BUSY && s_q.current_transfer_count == $past(s_q.initial_transfer_count)))
      else $error("launch did not load count");
   a_poll_no_irq: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.mode == BDC_MODE_POLL && s_q.stat == 2'h0) |=> ##0 (s_q.stat == 2'h0))
      else $error("status set in polling mode");
   a_fixed_fields: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == BDC_OFS_INIT) |=> (rdata[29:24] == 6'h04
      && rdata[31:30] == $past(s_q.src)))
      else $error("fixed fields wrong");

   // every counted unit is acknowledged on the next cycle
   a_ack_follows_unit: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_BUSY && unit_done)
      |=> unit_ack)
      else $error("unit not acknowledged");

   // a unit_done outside a busy channel is ignored
   a_ack_only_busy: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st != BDC_BUSY)
      |=> !unit_ack)
      else $error("unit acknowledged while not busy");

   // the terminal-count pulse follows the last unit
   a_tc_pulse_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_BUSY && unit_done && at_zero)
      |=> term_count)
      else $error("terminal count pulse missing");

   // no terminal-count pulse without the last unit
   a_tc_only_zero: assert property (@(posedge clk) disable iff (!rst_n)
      !(s_q.st == BDC_BUSY && unit_done && at_zero)
      |=> !term_count)
      else $error("spurious terminal count pulse");

   // without reload the channel parks idle with an empty count
   a_tc_count_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_BUSY && unit_done && at_zero && !s_q.ar && !cancel_cmd)
      |=> (s_q.current_transfer_count == 20'h00000 && s_q.st == BDC_IDLE))
      else $error("channel not parked at terminal count");

   // per-unit mode flags every unit moved
   a_unit_status_set: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.mode == BDC_MODE_UNIT && s_q.st == BDC_BUSY && unit_done)
      |=> s_q.stat[BDC_ST_UNIT])
      else $error("unit event not flagged");

   // terminal mode flags the terminal count
   a_tc_status_set: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.mode == BDC_MODE_TC && s_q.st == BDC_BUSY && unit_done && at_zero)
      |=> s_q.stat[BDC_ST_TC])
      else $error("terminal event not flagged");

   // per-unit mode never raises the terminal flag by itself
   a_unit_mode_no_tc: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.mode == BDC_MODE_UNIT && !s_q.stat[BDC_ST_TC])
      |=> !s_q.stat[BDC_ST_TC])
      else $error("terminal flag set in unit mode");

   // an unmasked terminal flag holds the interrupt line up
   a_irq_unmasked: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.stat[BDC_ST_TC] && s_q.mask[BDC_ST_TC])
      |-> irq)
      else $error("interrupt missing");

   // a fully masked channel keeps the interrupt line low
   a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.mask == 2'h0)
      |-> !irq)
      else $error("interrupt while masked");

   // a disabled channel never starts moving data
   a_go_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st != BDC_BUSY && !s_q.en)
      |=> !xfer_go)
      else $error("transfer started while disabled");

   // a synchronised request launches an armed channel
   a_req_launches: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_ARMED && s_q.en && req_s_q && s_q.request_disable_field == 2'h0 && !cancel_cmd)
      |=> xfer_go)
      else $error("request not serviced");

   // requests are refused while the request disable field is non-zero
   a_req_gated_qds: assert property (@(posedge clk) disable iff (!rst_n)
      (s_q.st == BDC_ARMED && !start_cmd && s_q.request_disable_field != 2'h0)
      |=> !xfer_go)
      else $error("request serviced while disabled");

   // the current count word reads back the live count and enable
   a_cur_readback: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == BDC_OFS_CUR)
      |=> (rdata[19:0] == $past(s_q.current_transfer_count) && rdata[20] == $past(s_q.en)))
      else $error("current count read wrong");

   // read data stands only in the cycle after a read strobe
   a_rdata_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      !bus.rd
      |=> (rdata == 32'h00000000))
      else $error("read data without read strobe");

endmodule : bdc_count_control

// file: core/bdc_pkg.sv
// package: register map, field layout and carrier types for the dma count/control block
package bdc_pkg;
   // register offsets (byte addresses, one 32-bit word each)
   localparam logic [7:0] BDC_OFS_INIT   = 8'h00; // initial_count_register
   localparam logic [7:0] BDC_OFS_CUR    = 8'h04; // current_count_register (read only)
   localparam logic [7:0] BDC_OFS_CMD    = 8'h08; // software start/cancel command
   localparam logic [7:0] BDC_OFS_STAT   = 8'h0c; // sticky event status, write one to clear
   localparam logic [7:0] BDC_OFS_MASK   = 8'h10; // interrupt mask
   localparam logic [7:0] BDC_OFS_CTRL   = 8'h14; // request disable field and destination size
   // field positions
   localparam int BDC_SRC_LSB  = 30;
   localparam int BDC_MODE_LSB = 22;
   localparam int BDC_AR_BIT   = 21;
   localparam int BDC_EN_BIT   = 20;
   localparam int BDC_CNT_W    = 20;
   // fixed reserved fields: handshake, unit transfer, no on-the-fly
   localparam logic [5:0] BDC_FIXED_FIELDS = 6'h04;
   // command bits
   localparam int BDC_CMD_START = 0;
   localparam int BDC_CMD_CANCEL = 1;
   // status bits
   localparam int BDC_ST_UNIT = 0;
   localparam int BDC_ST_TC   = 1;
   // reset values
   localparam logic [1:0] BDC_SRC_RST  = 2'h0;
   localparam logic [1:0] BDC_MODE_RST = 2'h0;
   localparam logic [1:0] BDC_QDS_RST  = 2'h0;
   localparam logic [1:0] BDC_DST_RST  = 2'h0;
   // interrupt modes
   localparam logic [1:0] BDC_MODE_POLL = 2'h0;
   localparam logic [1:0] BDC_MODE_UNIT = 2'h2;
   localparam logic [1:0] BDC_MODE_TC   = 2'h3;
   // destination size codes and their count steps
   localparam logic [1:0] BDC_DST_HALF = 2'h1;
   localparam logic [1:0] BDC_DST_WORD = 2'h2;
   localparam logic [19:0] BDC_STEP_BYTE = 20'h00001;
   localparam logic [19:0] BDC_STEP_HALF = 20'h00002;
   localparam logic [19:0] BDC_STEP_WORD = 20'h00004;

   typedef enum logic [1:0] { BDC_IDLE, BDC_ARMED, BDC_BUSY } bdc_state_e;

   // register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bdc_bus_s;

   // all block state except the request synchroniser flops
   typedef struct packed {
      bdc_state_e  st;
      logic [1:0]  src;
      logic [1:0]  mode;
      logic        ar;
      logic        en;
      logic [19:0] initial_transfer_count;
      logic [19:0] current_transfer_count;
      logic [1:0]  request_disable_field;
      logic [1:0]  dst;
      logic [1:0]  stat;
      logic [1:0]  mask;
      logic        unit_ack;
      logic        tc;
      logic [31:0] rdata;
   } bdc_state_s;
endpackage : bdc_pkg

// file: test/bdc_engine_model.sv
// transfer engine model: answers a busy channel with unit_done pulses
`timescale 1ns/1ns
module bdc_engine_model
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // channel side, gap sets the cycles between units
   input  wire logic       xfer_go,
   input  wire logic [4:0] gap,
   output logic            unit_done
);
   logic [4:0] cnt_q;
   // one-cycle pulse every gap+1 cycles while busy (every 2 for gap 0), silent otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q     <= 5'h00;
         unit_done <= 1'b0;
      end else begin
         unit_done <= xfer_go && (cnt_q == gap) && !unit_done;
         cnt_q     <= (!xfer_go || cnt_q == gap) ? 5'h00 : cnt_q + 5'h01;
      end
   end
endmodule : bdc_engine_model

// file: test/bridge_dma_count_control_bench.sv
// testbench: register sequences driving the dma count/control block
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module bridge_dma_count_control_bench;
   import bdc_pkg::*;
   logic        clk, rst_n, dma_req, unit_done, xfer_go, unit_ack, term_count, irq;
   bdc_bus_s    bus;
   logic [31:0] rdata;
   logic [4:0]  gap;
   int          failures, n_checks, acks, tcs;
   bdc_count_control dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .dma_req(dma_req), .unit_done(unit_done), .xfer_go(xfer_go), .unit_ack(unit_ack),
      .term_count(term_count), .irq(irq));
   bdc_engine_model eng (.clk(clk), .rst_n(rst_n), .xfer_go(xfer_go), .gap(gap),
      .unit_done(unit_done));
   // 25 MHz clock
   always #20 clk = ~clk;
   // count pulses of the engine side
   always @(posedge clk) begin
      if (unit_ack === 1'b1) acks <= acks + 1;
      if (term_count === 1'b1) tcs <= tcs + 1;
   end
   // count word layout: source, fixed fields, mode, reload, enable, count
   function automatic logic [31:0] mk(logic [1:0] s, logic [1:0] m, logic a, logic e,
                                      logic [19:0] c);
      return {s, BDC_FIXED_FIELDS, m, a, e, c};
   endfunction : mk
   task automatic report_and_stop();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
      #1;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic check_rd(logic [7:0] a, logic [31:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : check_rd
   task automatic wait_go(logic v);
      for (int i = 0; i < 400 && xfer_go !== v; i++) @(posedge clk);
      #1;
      if (xfer_go !== v) begin failures++; report_and_stop(); end
   endtask : wait_go
   task automatic wait_ack(int n);
      for (int i = 0; i < 400 && acks < n; i++) @(posedge clk);
      #1;
      if (acks < n) begin failures++; report_and_stop(); end
   endtask : wait_ack
   task automatic test_end(string name);
      $display("test %s done, failures so far %0d", name, failures);
   endtask : test_end
   // main sequence
   initial begin
      clk = 1'b0; rst_n = 1'b0; bus = '0; dma_req = 1'b0; gap = 5'h03;
      failures = 0; n_checks = 0; acks = 0; tcs = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      check_rd(BDC_OFS_INIT, mk(2'h0, 2'h0, 1'b0, 1'b0, 20'h0));
      check_rd(8'h3c, 32'h0);
      test_end("reset");
      wr(BDC_OFS_CTRL, 32'h0);
      wr(BDC_OFS_INIT, mk(2'h1, BDC_MODE_POLL, 1'b0, 1'b0, 20'h3));
      wr(8'h08, 32'h1);
      repeat (8) @(posedge clk);
      `CHK(xfer_go, 1'b0)
      test_end("enable_clear");
      wr(BDC_OFS_MASK, 32'h2);
      wr(BDC_OFS_INIT, mk(2'h1, BDC_MODE_TC, 1'b0, 1'b0, 20'h3));
      wr(BDC_OFS_INIT, mk(2'h1, BDC_MODE_TC, 1'b0, 1'b1, 20'h3));
      wr(BDC_OFS_CMD, 32'h1);
      wait_go(1'b1);
      wait_go(1'b0);
      `CHK(acks, 3)
      `CHK(tcs, 1)
      check_rd(BDC_OFS_INIT, mk(2'h1, BDC_MODE_TC, 1'b0, 1'b0, 20'h3));
      check_rd(BDC_OFS_CUR, mk(2'h1, BDC_MODE_TC, 1'b0, 1'b0, 20'h0));
      `CHK(irq, 1'b1)
      check_rd(BDC_OFS_STAT, 32'h2);
      wr(BDC_OFS_STAT, 32'h2);
      `CHK(irq, 1'b0)
      test_end("byte_terminal");
      wr(BDC_OFS_CTRL, 32'h20);
      wr(BDC_OFS_MASK, 32'h1);
      wr(BDC_OFS_INIT, mk(2'h1, BDC_MODE_UNIT, 1'b1, 1'b0, 20'h8));
      wr(BDC_OFS_INIT, mk(2'h1, BDC_MODE_UNIT, 1'b1, 1'b1, 20'h8));
      gap <= 5'h0c;
      wr(BDC_OFS_CMD, 32'h1);
      wait_ack(4);
      check_rd(BDC_OFS_CUR, mk(2'h1, BDC_MODE_UNIT, 1'b1, 1'b1, 20'h4));
      `CHK(irq, 1'b1)
      wait_go(1'b0);
      repeat (10) @(posedge clk);
      `CHK(xfer_go, 1'b0)
      check_rd(BDC_OFS_INIT, mk(2'h1, BDC_MODE_UNIT, 1'b1, 1'b1, 20'h8));
      check_rd(BDC_OFS_CUR, mk(2'h1, BDC_MODE_UNIT, 1'b1, 1'b1, 20'h8));
      check_rd(BDC_OFS_STAT, 32'h1);
      test_end("word_reload");
      dma_req <= 1'b1;
      wait_go(1'b1);
      dma_req <= 1'b0;
      wr(BDC_OFS_CMD, 32'h2);
      wait_go(1'b0);
      check_rd(BDC_OFS_INIT, mk(2'h1, BDC_MODE_UNIT, 1'b1, 1'b0, 20'h8));
      test_end("request_cancel");
      report_and_stop();
   end
endmodule : bridge_dma_count_control_bench
